// ===== logic/crfp_pkg.sv
package crfp_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int PICK_TIMEOUT_MS = 18;
	localparam int MOTION_TIMEOUT_MS = 50;
	localparam int PICK_TIMEOUT_CYC = (CLK_HZ / 1000) * PICK_TIMEOUT_MS;
	localparam int MOTION_TIMEOUT_CYC = (CLK_HZ / 1000) * MOTION_TIMEOUT_MS;
	localparam int TIMER_W = 21;
	localparam int STACK_LIMIT = 1000;
	localparam int STACK_W = 10;
	localparam int COL_W = 16;
	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h10;

	localparam int CTRL_READ_CMD_BIT = 0;

	localparam int ST_STARTED_BIT = 0;
	localparam int ST_TROUBLE_BIT = 1;
	localparam int ST_MOTOR_BIT = 2;
	localparam int ST_TEST_BIT = 3;
	localparam int ST_FAULT_LSB = 4;
	localparam int ST_PICKING_BIT = 10;
	localparam int ST_READING_BIT = 11;
	localparam int ST_CMD_PEND_BIT = 12;

	localparam int FAULT_N = 6;
	localparam int F_MOTION = 0;
	localparam int F_LIGHT = 1;
	localparam int F_DARK = 2;
	localparam int F_PICK = 3;
	localparam int F_HOPPER = 4;
	localparam int F_STACKER = 5;

	localparam int IRQ_N = 4;
	localparam int IRQ_TROUBLE_BIT = 0;
	localparam int IRQ_CARD_BIT = 1;
	localparam int IRQ_EOF_BIT = 2;
	localparam int IRQ_START_BIT = 3;
	localparam logic [IRQ_N-1:0] IRQ_MASK_RESET = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_PICK,
		SEQ_READ
	} crfp_seq_t;
endpackage : crfp_pkg

// ===== logic/crfp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module crfp_timer #(
	parameter int W = 21,
	parameter int LIMIT = 450000
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_run,
	output logic o_expired
);
	logic [W-1:0] count_reg;

	// Restarts whenever run drops; expiry holds until then
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_reg <= '0;
			o_expired <= 1'b0;
		end else if (!i_run) begin
			count_reg <= '0;
			o_expired <= 1'b0;
		end else if (count_reg == W'(LIMIT - 1)) begin
			o_expired <= 1'b1;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end
endmodule : crfp_timer
`default_nettype wire

// ===== logic/crfp_top.sv
// Contract
// - Card not through read station within 50 ms raises transport timing fault.
// - Trailing edge a third column or more off column timing raises same fault.
// - No light seen between pick and leading edge flags illumination fault, held.
// - Sensors not darkened before column 1 flags darkening fault, held.
// - Card not at station 18 ms after picker energized flags feed timeout, held.
// - Empty hopper sets flag until cards reloaded and clear pressed.
// - Stacker near 1000 cards sets flag until emptied and clear pressed.
// - Trouble output shows any detected trouble, otherwise none.
// - Start enters started state unless trouble is present.
// - Stop enters stopped off-line state and ceases picking and reading.
// - Clear resets logic and restarts motor once trouble is corrected.
// - Test mode acts as if select and read commands arrive continuously.
// - Start in test mode begins picking at maximum throttled rate.
// - Deck_finished_request switch press generates an deck_finished_request signal.
// - Power switched on produces a reset pulse to initial conditions.
`timescale 1ns/1ps
`default_nettype none
module crfp_top
	import crfp_pkg::*;
#(
	parameter int PICK_CYC = crfp_pkg::PICK_TIMEOUT_CYC,
	parameter int MOTION_CYC = crfp_pkg::MOTION_TIMEOUT_CYC,
	parameter int STACK_MAX = crfp_pkg::STACK_LIMIT
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_power_sw,
	input wire logic i_start_sw,
	input wire logic i_stop_sw,
	input wire logic i_clear_sw,
	input wire logic i_test_sw,
	input wire logic i_eof_sw,
	input wire logic i_card_at_station,
	input wire logic i_read_light,
	input wire logic i_station_dark,
	input wire logic i_col_strobe,
	input wire logic i_trail_edge,
	input wire logic i_hopper_empty,
	input wire logic i_stacker_emptied,
	output logic o_picker,
	output logic o_motor_run,
	output logic o_started,
	output logic o_trouble,
	output logic o_test_mode,
	output logic o_deck_finished_request,
	output logic o_power_on_reset,
	output logic o_irq,
	input wire logic [crfp_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [crfp_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	import crfp_pkg::*;

	crfp_seq_t seq_reg, seq_next;
	logic [FAULT_N-1:0] fault_reg, fault_next, fault_set, fault_fixed;
	logic [IRQ_N-1:0] irq_stat_reg, irq_mask_reg, irq_events, irq_clr;
	logic [STACK_W-1:0] stack_cnt_reg;
	logic [COL_W-1:0] col_cnt_reg, col_period_reg;
	logic col_valid_reg, dark_seen_reg, col1_seen_reg, cmd_pend_reg;
	logic start_d_reg, stop_d_reg, clear_d_reg, eof_d_reg, power_d_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_held_reg, w_held_reg;

	// Switch presses and power-on edge
	wire start_press = i_start_sw & ~start_d_reg;
	wire stop_press = i_stop_sw & ~stop_d_reg;
	wire clear_press = i_clear_sw & ~clear_d_reg;
	wire eof_press = i_eof_sw & ~eof_d_reg;
	wire power_rise = i_power_sw & ~power_d_reg;
	wire init = ~i_power_sw | power_rise;

	wire trouble_now = |fault_reg;
	wire pick_timeout;
	wire motion_timeout;

	// Demand for a card: host command or continuous in test mode
	wire read_demand = i_test_sw | cmd_pend_reg;
	wire may_pick = o_started & o_motor_run & ~trouble_now & read_demand;

	// Column phase of trailing edge, compared as thirds of a column
	wire [COL_W+1:0] phase3 = {2'b00, col_cnt_reg} * (COL_W+2)'(3);
	wire [COL_W+1:0] rest3 = {2'b00, col_period_reg - col_cnt_reg} * (COL_W+2)'(3);
	wire [COL_W+1:0] period_w = {2'b00, col_period_reg};
	wire trail_skew = col_valid_reg & (phase3 >= period_w) & (rest3 >= period_w);

	wire in_pick = (seq_reg == SEQ_PICK);
	wire in_read = (seq_reg == SEQ_READ);
	wire card_done = in_read & i_trail_edge;

	crfp_timer #(
		.W(TIMER_W),
		.LIMIT(PICK_CYC)
	) u_pick_timer (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_run(in_pick),
		.o_expired(pick_timeout)
	);

	crfp_timer #(
		.W(TIMER_W),
		.LIMIT(MOTION_CYC)
	) u_motion_timer (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_run(in_read),
		.o_expired(motion_timeout)
	);

	// Fault detection
	assign fault_set[F_MOTION] = in_read & (motion_timeout | (i_trail_edge & trail_skew));
	assign fault_set[F_LIGHT] = in_pick & ~i_card_at_station & ~i_read_light;
	assign fault_set[F_DARK] = in_read & i_col_strobe & ~col1_seen_reg & ~dark_seen_reg
		& ~i_station_dark;
	assign fault_set[F_PICK] = in_pick & pick_timeout & ~i_card_at_station;
	assign fault_set[F_HOPPER] = i_hopper_empty;
	// Emptying clear resets the count in the same cycle
	assign fault_set[F_STACKER] = (stack_cnt_reg >= STACK_W'(STACK_MAX))
		& ~(clear_press & i_stacker_emptied);

	// Condition corrected, so that clear may drop the flag
	assign fault_fixed[F_MOTION] = ~i_card_at_station;
	assign fault_fixed[F_LIGHT] = i_read_light;
	assign fault_fixed[F_DARK] = 1'b1;
	assign fault_fixed[F_PICK] = 1'b1;
	assign fault_fixed[F_HOPPER] = ~i_hopper_empty;
	assign fault_fixed[F_STACKER] = i_stacker_emptied;

	// Set wins over clear
	assign fault_next = (fault_reg & ~({FAULT_N{clear_press}} & fault_fixed)) | fault_set;
	wire trouble_next = |fault_next;

	// Card sequencing
	always_comb begin
		seq_next = seq_reg;
		unique case (seq_reg)
			SEQ_IDLE: begin
				if (may_pick) begin
					seq_next = SEQ_PICK;
				end
			end
			SEQ_PICK: begin
				if (i_card_at_station) begin
					seq_next = SEQ_READ;
				end
			end
			SEQ_READ: begin
				if (i_trail_edge) begin
					seq_next = SEQ_IDLE;
				end
			end
		endcase
		if (stop_press | clear_press | (|fault_set)) begin
			seq_next = SEQ_IDLE;
		end
	end

	// AXI4-Lite decode
	wire aw_fire = i_awvalid & o_awready;
	wire w_fire = i_wvalid & o_wready;
	wire wr_go = aw_held_reg & w_held_reg & ~o_bvalid;
	wire ar_fire = i_arvalid & o_arready;
	wire wr_ctrl = wr_go & (aw_addr_reg == CTRL_OFS);
	wire wr_mask = wr_go & (aw_addr_reg == IRQ_MASK_OFS);
	wire wr_known = wr_ctrl | wr_mask | (aw_addr_reg == STATUS_OFS)
		| (aw_addr_reg == IRQ_STAT_OFS) | (aw_addr_reg == COUNT_OFS);
	wire read_cmd_wr = wr_ctrl & w_strb_reg[0] & w_data_reg[CTRL_READ_CMD_BIT];

	wire [31:0] status_word = {19'h0, cmd_pend_reg, in_read, in_pick, fault_reg,
		i_test_sw, o_motor_run, trouble_now, o_started};
	wire rd_known = (i_araddr == CTRL_OFS) | (i_araddr == STATUS_OFS)
		| (i_araddr == IRQ_STAT_OFS) | (i_araddr == IRQ_MASK_OFS)
		| (i_araddr == COUNT_OFS);
	wire [31:0] rd_word = (i_araddr == CTRL_OFS) ? {31'h0, cmd_pend_reg} :
		(i_araddr == STATUS_OFS) ? status_word :
		(i_araddr == IRQ_STAT_OFS) ? {28'h0, irq_stat_reg} :
		(i_araddr == IRQ_MASK_OFS) ? {28'h0, irq_mask_reg} :
		(i_araddr == COUNT_OFS) ? {22'h0, stack_cnt_reg} : 32'h0;

	// Interrupt events; read of status clears, new event wins
	assign irq_events[IRQ_TROUBLE_BIT] = trouble_next & ~trouble_now;
	assign irq_events[IRQ_CARD_BIT] = card_done;
	assign irq_events[IRQ_EOF_BIT] = eof_press;
	assign irq_events[IRQ_START_BIT] = start_press & ~trouble_now & ~o_started;
	assign irq_clr = {IRQ_N{ar_fire & (i_araddr == IRQ_STAT_OFS)}};
	wire [IRQ_N-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_events;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			start_d_reg <= 1'b0;
			stop_d_reg <= 1'b0;
			clear_d_reg <= 1'b0;
			eof_d_reg <= 1'b0;
			power_d_reg <= 1'b0;
		end else begin
			start_d_reg <= i_start_sw;
			stop_d_reg <= i_stop_sw;
			clear_d_reg <= i_clear_sw;
			eof_d_reg <= i_eof_sw;
			power_d_reg <= i_power_sw;
		end
	end

	// Operating state, faults and panel outputs
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seq_reg <= SEQ_IDLE;
			fault_reg <= '0;
			o_started <= 1'b0;
			o_motor_run <= 1'b0;
			o_trouble <= 1'b0;
			o_picker <= 1'b0;
			o_test_mode <= 1'b0;
			o_deck_finished_request <= 1'b0;
			o_power_on_reset <= 1'b1;
			cmd_pend_reg <= 1'b0;
		end else if (init) begin
			seq_reg <= SEQ_IDLE;
			fault_reg <= '0;
			o_started <= 1'b0;
			o_motor_run <= i_power_sw;
			o_trouble <= 1'b0;
			o_picker <= 1'b0;
			o_test_mode <= i_test_sw;
			o_deck_finished_request <= 1'b0;
			o_power_on_reset <= power_rise;
			cmd_pend_reg <= 1'b0;
		end else begin
			seq_reg <= seq_next;
			fault_reg <= fault_next;
			o_trouble <= trouble_next;
			o_picker <= (seq_next == SEQ_PICK);
			o_test_mode <= i_test_sw;
			o_deck_finished_request <= eof_press;
			o_power_on_reset <= 1'b0;
			if (stop_press | trouble_next) begin
				o_started <= 1'b0;
			end else if (start_press) begin
				o_started <= 1'b1;
			end
			if (fault_set[F_MOTION]) begin
				o_motor_run <= 1'b0;
			end else if (clear_press & ~trouble_next) begin
				o_motor_run <= 1'b1;
			end
			if (stop_press | clear_press | init) begin
				cmd_pend_reg <= 1'b0;
			end else if (read_cmd_wr) begin
				cmd_pend_reg <= 1'b1;
			end else if (in_pick) begin
				cmd_pend_reg <= 1'b0;
			end
		end
	end

	// Column timing and per-card tracking
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			col_cnt_reg <= '0;
			col_period_reg <= '0;
			col_valid_reg <= 1'b0;
			dark_seen_reg <= 1'b0;
			col1_seen_reg <= 1'b0;
		end else if (!in_read) begin
			col_cnt_reg <= '0;
			col_period_reg <= '0;
			col_valid_reg <= 1'b0;
			dark_seen_reg <= 1'b0;
			col1_seen_reg <= 1'b0;
		end else begin
			if (i_station_dark) begin
				dark_seen_reg <= 1'b1;
			end
			if (i_col_strobe) begin
				col_cnt_reg <= COL_W'(1); // Whole cycles since strobe
				col1_seen_reg <= 1'b1;
				col_period_reg <= col_cnt_reg;
				col_valid_reg <= col1_seen_reg;
			end else if (col_cnt_reg != {COL_W{1'b1}}) begin
				col_cnt_reg <= col_cnt_reg + 1'b1;
			end
		end
	end

	// Stacker fill count
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stack_cnt_reg <= '0;
		end else if (clear_press & i_stacker_emptied) begin
			stack_cnt_reg <= '0;
		end else if (card_done & ~fault_set[F_STACKER]) begin
			stack_cnt_reg <= stack_cnt_reg + 1'b1;
		end
	end

	// Interrupt registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= IRQ_MASK_RESET;
			o_irq <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (wr_mask & w_strb_reg[0]) begin
				irq_mask_reg <= w_data_reg[IRQ_N-1:0];
			end
			o_irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// AXI4-Lite write channel
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (w_fire) begin
				w_held_reg <= 1'b1;
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (wr_go) begin
				o_bvalid <= 1'b1;
				o_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
			if (o_bvalid & i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= RESP_OKAY;
		end else if (ar_fire) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= rd_word;
			o_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (o_rvalid & i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end
endmodule : crfp_top
`default_nettype wire

// ===== tb/crfp_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module crfp_tb_top;
	import crfp_pkg::*;
	// Expected fault bit per failure mode, mode 1 in the low word
	localparam logic [79:0] FB = {16'(1 << (ST_FAULT_LSB + F_MOTION)),
		16'(1 << (ST_FAULT_LSB + F_LIGHT)), 16'(1 << (ST_FAULT_LSB + F_MOTION)),
		16'(1 << (ST_FAULT_LSB + F_DARK)), 16'(1 << (ST_FAULT_LSB + F_PICK))};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic pwr = 1'b1;
	logic tst = 1'b0;
	logic hop = 1'b0;
	logic emp = 1'b0;
	logic [3:0] sw = 4'h0;
	logic [2:0] mode = 3'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b0;
	logic rready = 1'b0;
	int eof_cnt = 0;
	wire eofr;
	logic [31:0] d;
	logic [1:0] r;
	wire card, dark, strb, trail, light, picker, motor, started, trouble, tmode, por, irq;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (eofr === 1'b1) begin
			eof_cnt <= eof_cnt + 1;
		end
	end
	crfp_transport_model i_crfp_transport_model (.i_clk(clk), .i_picker(picker), .i_mode(mode),
		.o_card(card), .o_dark(dark), .o_strobe(strb), .o_trail(trail), .o_light(light));
	crfp_top #(.PICK_CYC(50), .MOTION_CYC(200), .STACK_MAX(12)) i_crfp_top (.i_clk(clk),
		.i_arst_n(arst_n), .i_power_sw(pwr), .i_start_sw(sw[0]), .i_stop_sw(sw[1]),
		.i_clear_sw(sw[2]), .i_test_sw(tst), .i_eof_sw(sw[3]), .i_card_at_station(card),
		.i_read_light(light), .i_station_dark(dark), .i_col_strobe(strb), .i_trail_edge(trail),
		.i_hopper_empty(hop), .i_stacker_emptied(emp), .o_picker(picker), .o_motor_run(motor),
		.o_started(started), .o_trouble(trouble), .o_test_mode(tmode),
		.o_deck_finished_request(eofr), .o_power_on_reset(por), .o_irq(irq), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
	task end_sim();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			end_sim();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
		@(posedge clk);
	endtask : wr
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		@(posedge clk);
	endtask : rd
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		rd(a);
		chk(32'(r), (a > COUNT_OFS) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
		chk(d & m, e);
	endtask : rdc
	task press(input int k);
		sw[k] <= 1'b1;
		tick(2);
		sw[k] <= 1'b0;
		tick(3);
	endtask : press
	task wait_trb();
		while (trouble !== 1'b1) @(posedge clk);
		tick(3);
	endtask : wait_trb
	initial begin
		tick(6);
		arst_n <= 1'b1;
		tick(2);
		pwr <= 1'b0;
		tick(3);
		pwr <= 1'b1;
		tick(2);
		chk(32'(por), 32'h1);
		tick(1);
		chk(32'(por), 32'h0);
		rdc(IRQ_MASK_OFS, 32'h0, 32'hffffffff);
		rdc(STATUS_OFS, 32'h1 << ST_MOTOR_BIT, 32'h1fff);
		rdc(8'h20, 32'h0, 32'hffffffff);
		wr(8'h20, 32'h1, RESP_SLVERR);
		wr(IRQ_MASK_OFS, 32'hf, RESP_OKAY);
		rdc(IRQ_MASK_OFS, 32'hf, 32'hffffffff);
		press(2);
		chk(32'(motor), 32'h1);
		press(0);
		chk(32'(started), 32'h1);
		wr(CTRL_OFS, 32'h1, RESP_OKAY);
		tick(80);
		chk(32'(irq), 32'h1);
		rdc(IRQ_STAT_OFS, 32'ha, 32'hf);
		rdc(IRQ_STAT_OFS, 32'h0, 32'hf);
		rdc(COUNT_OFS, 32'h1, 32'hffffffff);
		tick(2);
		chk(32'(irq), 32'h0);
		wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
		press(3);
		chk(32'(irq), 32'h0);
		chk(32'(eof_cnt), 32'h1);
		rdc(IRQ_STAT_OFS, 32'h4, 32'hf);
		wr(IRQ_MASK_OFS, 32'hf, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			mode <= 3'(i + 1);
			wr(CTRL_OFS, 32'h1, RESP_OKAY);
			wait_trb();
			rdc(STATUS_OFS, 32'(FB[16*i+:16]), 32'h3f0);
			chk(32'(started), 32'h0);
			mode <= 3'h0;
			tick(400);
			press(2);
			chk(32'(trouble), 32'h0);
			chk(32'(motor), 32'h1);
			press(0);
		end
		press(1);
		chk(32'(started), 32'h0);
		chk(32'(picker), 32'h0);
		tst <= 1'b1;
		tick(2);
		chk(32'(tmode), 32'h1);
		press(0);
		chk(32'(picker), 32'h1);
		wait_trb();
		rdc(STATUS_OFS, 32'h1 << (ST_FAULT_LSB + F_STACKER), 32'h3f0);
		rd(COUNT_OFS);
		chk(32'(d >= 32'd12), 32'h1);
		press(0);
		chk(32'(started), 32'h0);
		tst <= 1'b0;
		emp <= 1'b1;
		press(2);
		chk(32'(trouble), 32'h0);
		emp <= 1'b0;
		hop <= 1'b1;
		tick(4);
		chk(32'(trouble), 32'h1);
		press(2);
		chk(32'(trouble), 32'h1);
		hop <= 1'b0;
		press(2);
		chk(32'(trouble), 32'h0);
		end_sim();
	end
endmodule : crfp_tb_top
`default_nettype wire

// ===== tb/crfp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module crfp_top_sva #(
	parameter int PICK_CYC = 50
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_power_sw,
	input wire logic i_start_sw,
	input wire logic i_stop_sw,
	input wire logic i_clear_sw,
	input wire logic i_test_sw,
	input wire logic i_eof_sw,
	input wire logic o_picker,
	input wire logic o_motor_run,
	input wire logic o_started,
	input wire logic o_trouble,
	input wire logic o_test_mode,
	input wire logic o_deck_finished_request,
	input wire logic o_power_on_reset
);
	int pick_cnt;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pick_cnt <= 0;
		end else begin
			pick_cnt <= o_picker ? pick_cnt + 1 : 0;
		end
	end
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	chk_start_refused: assert property ($rose(i_start_sw) && o_trouble |=> !o_started)
		else $error("start taken in trouble");
	chk_start_taken: assert property ($rose(i_start_sw) && !o_trouble && !i_stop_sw && i_power_sw
		&& o_motor_run |-> ##[1:2] o_started) else $error("start ignored");
	chk_stop_halts: assert property ($rose(i_stop_sw) |-> ##[1:2] (!o_started && !o_picker))
		else $error("stop did not halt");
	chk_trouble_stops: assert property (o_trouble && $past(o_trouble) |-> !o_started)
		else $error("started while in trouble");
	chk_trouble_held: assert property ($fell(o_trouble) |->
		$past(i_clear_sw) || $past(i_clear_sw, 2) || $past(i_clear_sw, 3))
		else $error("fault dropped without clear");
	chk_pick_bound: assert property (pick_cnt <= PICK_CYC + 2)
		else $error("picker held past timeout");
	chk_test_shown: assert property ($rose(i_test_sw) |-> ##[1:2] o_test_mode)
		else $error("test indicator missing");
	chk_eof_raised: assert property ($rose(i_eof_sw) && i_power_sw
		|-> ##[1:2] o_deck_finished_request) else $error("deck_finished_request not raised");
	chk_eof_single: assert property (o_deck_finished_request |=> !o_deck_finished_request)
		else $error("deck_finished_request not a pulse");
	chk_por_pulse: assert property ($rose(i_power_sw) |-> ##[0:2] o_power_on_reset)
		else $error("no power on reset pulse");
	cover property ($rose(o_trouble));
	cover property ($rose(o_picker) && o_test_mode);
	cover property (o_deck_finished_request);
endmodule : crfp_top_sva
bind crfp_top crfp_top_sva #(.PICK_CYC(PICK_CYC)) i_crfp_top_sva (.i_clk(i_clk),
	.i_arst_n(i_arst_n), .i_power_sw(i_power_sw), .i_start_sw(i_start_sw),
	.i_stop_sw(i_stop_sw), .i_clear_sw(i_clear_sw), .i_test_sw(i_test_sw),
	.i_eof_sw(i_eof_sw), .o_picker(o_picker), .o_motor_run(o_motor_run),
	.o_started(o_started), .o_trouble(o_trouble), .o_test_mode(o_test_mode),
	.o_deck_finished_request(o_deck_finished_request), .o_power_on_reset(o_power_on_reset));
`default_nettype wire

// ===== tb/crfp_transport_model.sv
`timescale 1ns/1ps
`default_nettype none
// Modes: 0 good, 1 no arrival, 2 no dark, 3 late trail, 4 no light, 5 stuck card
module crfp_transport_model (
	input wire logic i_clk,
	input wire logic i_picker,
	input wire logic [2:0] i_mode,
	output logic o_card,
	output logic o_dark,
	output logic o_strobe,
	output logic o_trail,
	output logic o_light
);
	assign o_light = (i_mode == 3'h4) ? 1'b0 : !o_card;
	initial begin
		o_card = 1'b0;
		o_dark = 1'b0;
		o_strobe = 1'b0;
		o_trail = 1'b0;
		forever begin
			do begin
				@(posedge i_clk);
			end while (!i_picker);
			if (i_mode == 3'h1) begin
				while (i_picker) @(posedge i_clk);
			end else begin
				repeat (10) @(posedge i_clk);
				o_card <= 1'b1;
				o_dark <= (i_mode != 3'h2);
				repeat (3) begin
					repeat (4) @(posedge i_clk);
					o_strobe <= 1'b1;
					@(posedge i_clk);
					o_strobe <= 1'b0;
				end
				if (i_mode == 3'h5) repeat (300) @(posedge i_clk);
				if (i_mode == 3'h3) @(posedge i_clk);
				o_trail <= (i_mode != 3'h5);
				o_card <= 1'b0;
				o_dark <= 1'b0;
				@(posedge i_clk);
				o_trail <= 1'b0;
			end
		end
	end
endmodule : crfp_transport_model
`default_nettype wire
